/* src/fps_defs.vh */
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH
// How it works
// - supply-off short check starts long recovery
// - short check skips waiting for over-power timer
// - three over-current cycles stop switching, run low
// - over-current fault waits timeout, restarts next supply-off
// - reference power-good loss stops switching, restarts supply
// - held-low reference keeps repeating restart cycle
// - thermal shutdown repeats restart while still hot
// - pin faults auto-recover, shorts mean ground
// - silicon first pulse over 2 us faults
// - gan first pulse limit 2 or 1 us
// - regulator below 14 V after 10 us restarts
// - three regulator over 15 V pulses restart
// - over-voltage sense held 750 us restarts
// - programming pin open or short blocks switching
// - no switching during long recovery timer
`define FPS_CLK_MHZ 200
`define FPS_LONG_RECOVERY_MS 1500
`define FPS_LONG_RECOVERY_CYC (`FPS_LONG_RECOVERY_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_OV_DELAY_US 750
`define FPS_OV_DELAY_CYC (`FPS_OV_DELAY_US * `FPS_CLK_MHZ)
`define FPS_REG_CHECK_US 10
`define FPS_REG_CHECK_CYC (`FPS_REG_CHECK_US * `FPS_CLK_MHZ)
`define FPS_PULSE_LONG_US 2
`define FPS_PULSE_LONG_CYC (`FPS_PULSE_LONG_US * `FPS_CLK_MHZ)
`define FPS_PULSE_SHORT_US 1
`define FPS_PULSE_SHORT_CYC (`FPS_PULSE_SHORT_US * `FPS_CLK_MHZ)
`define FPS_CONSEC_PULSES 3
`define FPS_CAUSE_NONE 4'h0
`define FPS_CAUSE_SHORT_OUT 4'h1
`define FPS_CAUSE_OVERCURRENT 4'h2
`define FPS_CAUSE_REF_LOW 4'h3
`define FPS_CAUSE_THERMAL 4'h4
`define FPS_CAUSE_SENSE_SHORT 4'h5
`define FPS_CAUSE_SENSE_OPEN 4'h6
`define FPS_CAUSE_REG_LOW 4'h7
`define FPS_CAUSE_REG_OVER 4'h8
`define FPS_CAUSE_OVP 4'h9
`define FPS_CAUSE_PROG_PIN 4'hA
`endif

/* src/fps_supervisor.v */
`timescale 1ns/1ps
`include "fps_defs.vh"
module fps_supervisor #(
  parameter [31:0] LONG_RECOVERY_CYC = `FPS_LONG_RECOVERY_CYC,
  parameter [31:0] OV_DELAY_CYC = `FPS_OV_DELAY_CYC
) (
  input wire REF_CLK,
  input wire SYS_RST,
  input wire SUPPLY_ON,
  input wire SUPPLY_OFF,
  input wire PEAK_OVER_OPP,
  input wire OUT_SENSE_LOW,
  input wire CS_OVER_OCP,
  input wire BLANK_DONE,
  input wire DEMAG_DONE,
  input wire LOW_SIDE_GATE_REQ,
  input wire REF_GOOD,
  input wire THERMAL_HOT,
  input wire SILICON_MODE,
  input wire FREQ_RES_HIGH,
  input wire REG_BELOW_14V,
  input wire REG_ABOVE_15V,
  input wire OVP_SENSE_HIGH,
  input wire PROG_PIN_OPEN,
  input wire PROG_PIN_SHORT,
  output reg SWITCH_EN,
  output reg RUN,
  output reg UVLO_RESTART,
  output reg LONG_RECOVERY,
  output reg [3:0] FAULT_CAUSE
);
  localparam [4:0] ST_START = 5'h01;
  localparam [4:0] ST_RUN = 5'h02;
  localparam [4:0] ST_UVLO = 5'h04;
  localparam [4:0] ST_WAIT = 5'h08;
  localparam [4:0] ST_REARM = 5'h10;
  localparam [31:0] REG_CHK_W = `FPS_REG_CHECK_CYC;
  localparam [31:0] LIM_LONG_W = `FPS_PULSE_LONG_CYC;
  localparam [31:0] LIM_SHORT_W = `FPS_PULSE_SHORT_CYC;
  localparam [31:0] CONSEC_W = `FPS_CONSEC_PULSES;
  localparam [15:0] REG_CHK = REG_CHK_W[15:0];
  localparam [15:0] LIM_LONG = LIM_LONG_W[15:0];
  localparam [15:0] LIM_SHORT = LIM_SHORT_W[15:0];
  localparam [1:0] CONSEC = CONSEC_W[1:0];

  reg [4:0] state_r;
  reg [31:0] tmr_r;
  reg [15:0] chk_r;
  reg [15:0] on_r;
  reg first_r;
  reg gate_d_r;
  reg oc_hit_r;
  reg ov_hit_r;
  reg [1:0] oc_cnt_r;
  reg [1:0] ov_cnt_r;
  reg [31:0] ovp_r;
  reg [3:0] cause_nxt;
  reg long_nxt;

  wire gate_fall = gate_d_r & ~LOW_SIDE_GATE_REQ;
  wire [15:0] first_lim = (SILICON_MODE | FREQ_RES_HIGH) ? LIM_LONG : LIM_SHORT;
  wire first_long = first_r & LOW_SIDE_GATE_REQ & (on_r >= first_lim - 16'h0001);
  wire oc_win = CS_OVER_OCP & BLANK_DONE & ~DEMAG_DONE;

  // run-time fault priority in one place: first one found fixes the response
  always @*
  begin
    cause_nxt = `FPS_CAUSE_NONE;
    long_nxt = 1'b0;
    if (SUPPLY_OFF & (PEAK_OVER_OPP | OUT_SENSE_LOW))
    begin
      cause_nxt = `FPS_CAUSE_SHORT_OUT;
      long_nxt = 1'b1;
    end
    else if (first_long)
    begin
      cause_nxt = `FPS_CAUSE_SENSE_SHORT;
      long_nxt = 1'b1;
    end
    else if (gate_fall & (oc_hit_r | oc_win) & oc_cnt_r == CONSEC - 2'h1)
    begin
      cause_nxt = `FPS_CAUSE_OVERCURRENT;
      long_nxt = 1'b1;
    end
    else if (gate_fall & REG_ABOVE_15V | gate_fall & ov_hit_r)
    begin
      if (ov_cnt_r == CONSEC - 2'h1)
        cause_nxt = `FPS_CAUSE_REG_OVER;
    end
    if (cause_nxt == `FPS_CAUSE_NONE)
    begin
      if (~REF_GOOD)
        cause_nxt = `FPS_CAUSE_REF_LOW;
      else if (THERMAL_HOT)
        cause_nxt = `FPS_CAUSE_THERMAL;
      else if (ovp_r >= OV_DELAY_CYC - 32'h0000_0001 && OVP_SENSE_HIGH)
        cause_nxt = `FPS_CAUSE_OVP;
    end
  end

  always @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_r <= ST_START;
      tmr_r <= 32'h0000_0000;
      chk_r <= 16'h0000;
      on_r <= 16'h0000;
      first_r <= 1'b0;
      gate_d_r <= 1'b0;
      oc_hit_r <= 1'b0;
      ov_hit_r <= 1'b0;
      oc_cnt_r <= 2'h0;
      ov_cnt_r <= 2'h0;
      ovp_r <= 32'h0000_0000;
      SWITCH_EN <= 1'b0;
      RUN <= 1'b0;
      UVLO_RESTART <= 1'b0;
      LONG_RECOVERY <= 1'b0;
      FAULT_CAUSE <= `FPS_CAUSE_NONE;
    end
    else
    begin
      gate_d_r <= LOW_SIDE_GATE_REQ;
      UVLO_RESTART <= 1'b0;
      ovp_r <= OVP_SENSE_HIGH ? ((ovp_r == 32'hFFFF_FFFF) ? ovp_r : ovp_r + 32'h0000_0001) : 32'h0000_0000;
      case (state_r)
        ST_START:
        begin
          SWITCH_EN <= 1'b0;
          RUN <= 1'b0;
          oc_cnt_r <= 2'h0;
          ov_cnt_r <= 2'h0;
          if (SUPPLY_ON)
          begin
            if (chk_r >= REG_CHK - 16'h0001)
            begin
              chk_r <= 16'h0000;
              if (REG_BELOW_14V | PROG_PIN_OPEN | PROG_PIN_SHORT | ~REF_GOOD | THERMAL_HOT)
              begin
                FAULT_CAUSE <= REG_BELOW_14V ? `FPS_CAUSE_REG_LOW :
                  (PROG_PIN_OPEN | PROG_PIN_SHORT) ? `FPS_CAUSE_PROG_PIN :
                  ~REF_GOOD ? `FPS_CAUSE_REF_LOW : `FPS_CAUSE_THERMAL;
                state_r <= ST_UVLO;
              end
              else
              begin
                SWITCH_EN <= 1'b1;
                RUN <= 1'b1;
                first_r <= 1'b1;
                on_r <= 16'h0000;
                FAULT_CAUSE <= `FPS_CAUSE_NONE;
                state_r <= ST_RUN;
              end
            end
            else
              chk_r <= chk_r + 16'h0001;
          end
          else
            chk_r <= 16'h0000;
        end
        ST_RUN:
        begin
          on_r <= LOW_SIDE_GATE_REQ ? on_r + 16'h0001 : 16'h0000;
          if (gate_fall)
            first_r <= 1'b0;
          if (LOW_SIDE_GATE_REQ & ~gate_d_r)
          begin
            oc_hit_r <= 1'b0;
            ov_hit_r <= 1'b0;
          end
          else
          begin
            oc_hit_r <= oc_hit_r | oc_win;
            ov_hit_r <= ov_hit_r | REG_ABOVE_15V;
          end
          if (gate_fall)
          begin
            oc_cnt_r <= (oc_hit_r | oc_win) ? oc_cnt_r + 2'h1 : 2'h0;
            ov_cnt_r <= (ov_hit_r | REG_ABOVE_15V) ? ov_cnt_r + 2'h1 : 2'h0;
          end
          if (cause_nxt != `FPS_CAUSE_NONE)
          begin
            SWITCH_EN <= 1'b0;
            RUN <= 1'b0;
            FAULT_CAUSE <= cause_nxt;
            tmr_r <= 32'h0000_0000;
            LONG_RECOVERY <= long_nxt;
            state_r <= long_nxt ? ST_WAIT : ST_UVLO;
          end
          else if (SUPPLY_OFF)
          begin
            SWITCH_EN <= 1'b0;
            RUN <= 1'b0;
            state_r <= ST_UVLO;
          end
        end
        ST_UVLO:
        begin
          UVLO_RESTART <= 1'b1;
          oc_cnt_r <= 2'h0;
          ov_cnt_r <= 2'h0;
          state_r <= ST_START;
        end
        ST_WAIT:
        begin
          SWITCH_EN <= 1'b0;
          if (tmr_r >= LONG_RECOVERY_CYC - 32'h0000_0001)
            state_r <= ST_REARM;
          else
            tmr_r <= tmr_r + 32'h0000_0001;
        end
        ST_REARM:
        begin
          if (SUPPLY_OFF)
          begin
            LONG_RECOVERY <= 1'b0;
            state_r <= ST_UVLO;
          end
        end
        default:
          state_r <= ST_START;
      endcase
    end
  end
endmodule

/* tb/fps_monitor.sv */
`timescale 1ns/1ps
module fps_monitor (
  input wire REF_CLK,
  input wire SYS_RST,
  input wire SUPPLY_OFF,
  input wire PEAK_OVER_OPP,
  input wire OUT_SENSE_LOW,
  input wire REF_GOOD,
  input wire THERMAL_HOT,
  input wire SWITCH_EN,
  input wire RUN,
  input wire UVLO_RESTART,
  input wire LONG_RECOVERY,
  input wire [3:0] FAULT_CAUSE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_short;
    SWITCH_EN && SUPPLY_OFF && (PEAK_OVER_OPP || OUT_SENSE_LOW);
  endsequence
  chk_short_recover: assert property (s_short |=> LONG_RECOVERY && !SWITCH_EN)
    else $error("short check missed");
  chk_ocp_trip: assert property ($fell(SWITCH_EN) && FAULT_CAUSE == 4'h2 |-> LONG_RECOVERY && !RUN)
    else $error("overcurrent trip bad");
  chk_ref_stop: assert property (SWITCH_EN && !REF_GOOD |=> !SWITCH_EN && !RUN)
    else $error("ref loss kept switching");
  chk_hot_stop: assert property (SWITCH_EN && THERMAL_HOT |=> !SWITCH_EN)
    else $error("hot kept switching");
  chk_recov_quiet: assert property (LONG_RECOVERY |-> !SWITCH_EN && !UVLO_RESTART)
    else $error("switching in recovery");
  chk_recov_hold: assert property ($rose(LONG_RECOVERY) |=> LONG_RECOVERY [*8])
    else $error("recovery too short");
  chk_recov_exit: assert property ($fell(LONG_RECOVERY) |-> ##[0:2] UVLO_RESTART)
    else $error("no restart after recovery");
  chk_uvlo_pulse: assert property (UVLO_RESTART |-> !SWITCH_EN && !RUN ##1 !UVLO_RESTART)
    else $error("restart pulse bad");
endmodule
bind fps_supervisor fps_monitor u_mon (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SUPPLY_OFF(SUPPLY_OFF),
  .PEAK_OVER_OPP(PEAK_OVER_OPP), .OUT_SENSE_LOW(OUT_SENSE_LOW), .REF_GOOD(REF_GOOD), .THERMAL_HOT(THERMAL_HOT),
  .SWITCH_EN(SWITCH_EN), .RUN(RUN), .UVLO_RESTART(UVLO_RESTART), .LONG_RECOVERY(LONG_RECOVERY),
  .FAULT_CAUSE(FAULT_CAUSE));

/* tb/fps_stage_model.sv */
`timescale 1ns/1ps
module fps_stage_model (
  input wire clk,
  input wire rst,
  input wire sw,
  input wire ocp,
  input wire hold,
  output wire gate,
  output wire blank,
  output wire demag,
  output wire cs_over
);
  reg [5:0] cnt_r;
  always @(posedge clk or posedge rst)
    if (rst || !sw)
      cnt_r <= 6'h00;
    else
      cnt_r <= cnt_r + 6'h01;
  // hold keeps the gate on to mimic a shorted sense pin
  assign gate = sw && (hold || !cnt_r[5]);
  assign blank = cnt_r > 6'h03;
  assign demag = cnt_r > 6'h30;
  assign cs_over = ocp && blank && !demag;
endmodule

/* tb/fps_supervisor_tb.sv */
`timescale 1ns/1ps
module fps_supervisor_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup_on = 1'b0, sup_off = 1'b0, peak = 1'b0, low = 1'b0, ocp = 1'b0, hold = 1'b0, si = 1'b1, frq = 1'b1;
  logic [6:0] flt = 7'h00;
  logic gate, blank, demag, cs_over, sw_en, run, uvlo, lrec;
  logic [3:0] cause;
  logic [3:0] codes [7] = '{4'h3, 4'h4, 4'hA, 4'hA, 4'h7, 4'h8, 4'h9};
  int n_errors = 0, cmp_count = 0, n;
  always #2.5 clk = ~clk;
  fps_supervisor #(.LONG_RECOVERY_CYC(32'h64), .OV_DELAY_CYC(32'h32)) u_dut (.REF_CLK(clk), .SYS_RST(rst),
    .SUPPLY_ON(sup_on), .SUPPLY_OFF(sup_off), .PEAK_OVER_OPP(peak), .OUT_SENSE_LOW(low), .CS_OVER_OCP(cs_over),
    .BLANK_DONE(blank), .DEMAG_DONE(demag), .LOW_SIDE_GATE_REQ(gate), .REF_GOOD(~flt[0]), .THERMAL_HOT(flt[1]),
    .SILICON_MODE(si), .FREQ_RES_HIGH(frq), .REG_BELOW_14V(flt[4]), .REG_ABOVE_15V(flt[5]),
    .OVP_SENSE_HIGH(flt[6]), .PROG_PIN_OPEN(flt[2]), .PROG_PIN_SHORT(flt[3]), .SWITCH_EN(sw_en), .RUN(run),
    .UVLO_RESTART(uvlo), .LONG_RECOVERY(lrec), .FAULT_CAUSE(cause));
  fps_stage_model u_stage (.clk(clk), .rst(rst), .sw(sw_en), .ocp(ocp), .hold(hold), .gate(gate), .blank(blank),
    .demag(demag), .cs_over(cs_over));
  task wrap_up;
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // sel 0 switching up, 1 switching down, 2 restart pulse
  task waitfor(input int lim, input int sel);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (n < lim && !(sel == 0 ? sw_en === 1'b1 : sel == 1 ? sw_en === 1'b0 : uvlo === 1'b1));
  endtask
  task run_up;
    @(posedge clk);
    sup_on <= 1'b1;
    waitfor(2100, 0);
  endtask
  // an early supply-off must not cut the timer short, nor a late fault replace the first
  task recover(input logic [3:0] c);
    repeat (20) @(posedge clk);
    sup_off <= 1'b1;
    flt <= 7'h03;
    @(posedge clk);
    sup_off <= 1'b0;
    flt <= 7'h00;
    repeat (100) @(posedge clk);
    #1 check("hold_lr", lrec, 4'h1);
    check("hold_cause", cause, c);
    @(posedge clk);
    sup_on <= 1'b0;
    sup_off <= 1'b1;
    waitfor(5, 2);
    check("uvlo", uvlo, 4'h1);
    check("lr_end", lrec, 4'h0);
    @(posedge clk);
    sup_off <= 1'b0;
  endtask
  task t_ocp;
    run_up();
    check("sw", sw_en, 4'h1);
    check("run", run, 4'h1);
    @(posedge clk);
    ocp <= 1'b1;
    waitfor(300, 1);
    check("n3", 4'(n > 128 && n <= 192), 4'h1);
    check("lrec", lrec, 4'h1);
    check("run", run, 4'h0);
    check("cause", cause, 4'h2);
    @(posedge clk);
    ocp <= 1'b0;
    recover(4'h2);
  endtask
  task t_short(input int sel);
    run_up();
    @(posedge clk);
    {peak, low, sup_off, sup_on} <= sel ? 4'hA : 4'h6;
    @(posedge clk);
    {peak, low, sup_off} <= 3'h0;
    #1 check("lrec", lrec, 4'h1);
    check("cause", cause, 4'h1);
    check("sw", sw_en, 4'h0);
    recover(4'h1);
  endtask
  task t_first(input int m);
    @(posedge clk);
    si <= m == 0;
    frq <= m == 1;
    hold <= 1'b1;
    run_up();
    waitfor(500, 1);
    check("ontime", 4'(n >= (m == 2 ? 200 : 400) && n <= (m == 2 ? 204 : 404)), 4'h1);
    check("cause", cause, 4'h5);
    check("lrec", lrec, 4'h1);
    @(posedge clk);
    hold <= 1'b0;
    si <= 1'b1;
    frq <= 1'b1;
    recover(4'h5);
  endtask
  // the second pass shows a held fault repeats the restart cycle
  task t_shut(input int sel);
    @(posedge clk);
    sup_on <= 1'b1;
    flt <= (sel > 1 && sel < 5) ? 7'h01 << sel : 7'h00;
    if (sel < 2 || sel > 4)
    begin
      waitfor(2100, 0);
      @(posedge clk);
      flt <= 7'h01 << sel;
    end
    repeat (2)
    begin
      waitfor(2400, 2);
      check("uvlo", uvlo, 4'h1);
      check("cause", cause, codes[sel]);
      check("sw", sw_en, 4'h0);
      if (sel > 1 && sel < 5)
        check("t10us", 4'(n >= 2000 && n <= 2002), 4'h1);
      @(posedge clk);
      sup_on <= 1'b0;
      @(posedge clk);
      sup_on <= 1'b1;
    end
    @(posedge clk);
    sup_on <= 1'b0;
    flt <= 7'h00;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_ocp();
    t_short(0);
    t_short(1);
    for (int m = 0; m < 3; m++)
      t_first(m);
    for (int s = 0; s < 7; s++)
      t_shut(s);
    wrap_up();
  end
  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end
endmodule
